// ---- src/spfp_port.sv ----
// Shared printer / floppy port with AXI4-Lite register access
// Function
// - Status bit 7 reads inverted busy
// - Status bit 5 reads out-of-paper input
// - Status bit 4 reads online input
// - Status bit 3 reads fault_n input
// - Auto feed output is inverse control bit1
// - Printer reset output follows control bit 2
// - Choose output is inverse control bit 3
// - Head side high for side 0
// - Direction high outward, low inward
// - One low step pulse per track
// - Write gate asserted just before write data
// - Write data falling edge per flux transition
// - Shared pin is motor select drive 1
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module spfp_port #(
	parameter int STEP_LOW = spfp_pkg::STEP_LOW_CYC,
	parameter int STEP_GAP = spfp_pkg::STEP_GAP_CYC,
	parameter int BIT_CELL = spfp_pkg::BIT_CELL_CYC,
	parameter int FLUX_LOW = spfp_pkg::FLUX_LOW_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire spfp_pkg::spfp_pad_t padIn,
	output spfp_pkg::spfp_pad_t padOut,
	output spfp_pkg::spfp_pad_t padOe,
	output logic autoFeedMotorN,
	output logic initDir,
	output logic chooseStepN,
	output logic irq
);

	typedef enum logic [2:0] {
		SPFP_STEP_IDLE = 3'b001,
		SPFP_STEP_LOW = 3'b010,
		SPFP_STEP_GAP = 3'b100
	} spfp_step_t;

	typedef enum logic [1:0] {
		SPFP_WR_IDLE = 2'b01,
		SPFP_WR_CELL = 2'b10
	} spfp_wr_t;

	// ----------------------------------------------------------------
	// Pad input synchronisers
	// ----------------------------------------------------------------
	spfp_pkg::spfp_pad_t padMeta_ff;
	spfp_pkg::spfp_pad_t padSync_ff;
	logic busyPrev_ff;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			padMeta_ff <= '0;
			padSync_ff <= '0;
			busyPrev_ff <= 1'b0;
		end else begin
			padMeta_ff <= padIn;
			padSync_ff <= padMeta_ff;
			busyPrev_ff <= padSync_ff.busyMotor;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic awHeld_ff;
	logic wHeld_ff;
	logic [7:0] awAddr_ff;
	logic [7:0] wData_ff;
	logic wLane0_ff;
	logic awready_ff;
	logic wready_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic arready_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic doWrite;
	logic doRead;
	logic wrOk;
	logic rdOk;
	logic [7:0] rdByte;

	logic [7:0] control_ff;
	logic [7:0] mode_ff;
	logic [7:0] floppy_ff;
	logic [7:0] irqMask_ff;
	logic [7:0] irqStat_ff;
	logic [7:0] statusByte;
	logic [7:0] fstatByte;
	logic floppyMode;

	assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
	assign doRead = s_axi_arvalid && arready_ff;
	assign floppyMode = mode_ff[spfp_pkg::MD_FLOPPY];

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff <= 8'h00;
			wLane0_ff <= 1'b0;
			awready_ff <= 1'b1;
			wready_ff <= 1'b1;
			bvalid_ff <= 1'b0;
			bresp_ff <= spfp_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && awready_ff) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= s_axi_awaddr;
				awready_ff <= 1'b0;
			end else if (doWrite) begin
				awHeld_ff <= 1'b0;
				awready_ff <= 1'b1;
			end
			if (s_axi_wvalid && wready_ff) begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata[7:0];
				wLane0_ff <= s_axi_wstrb[0];
				wready_ff <= 1'b0;
			end else if (doWrite) begin
				wHeld_ff <= 1'b0;
				wready_ff <= 1'b1;
			end
			if (doWrite) begin
				bvalid_ff <= 1'b1;
				bresp_ff <= wrOk ? spfp_pkg::RESP_OKAY : spfp_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (awAddr_ff)
			spfp_pkg::ADDR_STATUS, spfp_pkg::ADDR_CONTROL, spfp_pkg::ADDR_MODE,
			spfp_pkg::ADDR_FLOPPY, spfp_pkg::ADDR_STEP, spfp_pkg::ADDR_WDATA,
			spfp_pkg::ADDR_FSTAT, spfp_pkg::ADDR_IRQ_STAT,
			spfp_pkg::ADDR_IRQ_MASK: wrOk = 1'b1;
			default: wrOk = 1'b0;
		endcase
	end

	always_comb begin
		rdOk = 1'b1;
		unique case (s_axi_araddr)
			spfp_pkg::ADDR_STATUS: rdByte = statusByte;
			spfp_pkg::ADDR_CONTROL: rdByte = control_ff;
			spfp_pkg::ADDR_MODE: rdByte = mode_ff;
			spfp_pkg::ADDR_FLOPPY: rdByte = floppy_ff;
			spfp_pkg::ADDR_STEP: rdByte = 8'h00;
			spfp_pkg::ADDR_WDATA: rdByte = 8'h00;
			spfp_pkg::ADDR_FSTAT: rdByte = fstatByte;
			spfp_pkg::ADDR_IRQ_STAT: rdByte = irqStat_ff;
			spfp_pkg::ADDR_IRQ_MASK: rdByte = irqMask_ff;
			default: begin
				rdByte = 8'h00;
				rdOk = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= spfp_pkg::RESP_OKAY;
		end else if (doRead) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= {24'h000000, rdByte};
			rresp_ff <= rdOk ? spfp_pkg::RESP_OKAY : spfp_pkg::RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic regWe;
	logic stepStart;
	logic byteStart;
	logic wrLoad;

	assign regWe = doWrite && wLane0_ff;

	// Printer status is a live view, not a stored value
	assign statusByte = {~padSync_ff.busyMotor,
		1'b0,
		padSync_ff.mediaWdata,
		padSync_ff.onlineGate,
		padSync_ff.faultSide,
		3'b000};

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			control_ff <= spfp_pkg::RST_CONTROL;
			mode_ff <= spfp_pkg::RST_MODE;
			floppy_ff <= spfp_pkg::RST_FLOPPY;
			irqMask_ff <= spfp_pkg::RST_IRQ_MASK;
		end else if (regWe) begin
			if (awAddr_ff == spfp_pkg::ADDR_CONTROL) begin
				control_ff <= wData_ff;
			end
			if (awAddr_ff == spfp_pkg::ADDR_MODE) begin
				mode_ff <= wData_ff;
			end
			if (awAddr_ff == spfp_pkg::ADDR_FLOPPY) begin
				floppy_ff <= wData_ff;
			end
			if (awAddr_ff == spfp_pkg::ADDR_IRQ_MASK) begin
				irqMask_ff <= wData_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// Step pulse engine
	// ----------------------------------------------------------------
	spfp_step_t stepState_ff;
	logic [7:0] stepLeft_ff;
	logic [15:0] stepCnt_ff;
	logic stepDone;

	assign stepStart = regWe && awAddr_ff == spfp_pkg::ADDR_STEP && floppyMode
		&& stepState_ff == SPFP_STEP_IDLE && wData_ff != 8'h00;
	assign stepDone = stepState_ff == SPFP_STEP_GAP && stepCnt_ff == 16'h0000
		&& stepLeft_ff == 8'h00;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			stepState_ff <= SPFP_STEP_IDLE;
			stepLeft_ff <= 8'h00;
			stepCnt_ff <= 16'h0000;
		end else if (!floppyMode) begin
			stepState_ff <= SPFP_STEP_IDLE;
			stepLeft_ff <= 8'h00;
		end else begin
			unique case (stepState_ff)
				SPFP_STEP_IDLE: begin
					if (stepStart) begin
						stepState_ff <= SPFP_STEP_LOW;
						stepLeft_ff <= wData_ff - 8'h01;
						stepCnt_ff <= 16'(STEP_LOW - 1);
					end
				end
				SPFP_STEP_LOW: begin
					if (stepCnt_ff == 16'h0000) begin
						stepState_ff <= SPFP_STEP_GAP;
						stepCnt_ff <= 16'(STEP_GAP - 1);
					end else begin
						stepCnt_ff <= stepCnt_ff - 16'h0001;
					end
				end
				SPFP_STEP_GAP: begin
					// One low pulse per track, then a settle gap
					if (stepCnt_ff != 16'h0000) begin
						stepCnt_ff <= stepCnt_ff - 16'h0001;
					end else if (stepLeft_ff == 8'h00) begin
						stepState_ff <= SPFP_STEP_IDLE;
					end else begin
						stepState_ff <= SPFP_STEP_LOW;
						stepLeft_ff <= stepLeft_ff - 8'h01;
						stepCnt_ff <= 16'(STEP_LOW - 1);
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Write data serialiser
	// ----------------------------------------------------------------
	spfp_wr_t wrState_ff;
	logic [7:0] wrShift_ff;
	logic [2:0] wrBit_ff;
	logic [15:0] wrCnt_ff;
	logic gateLead_ff;
	logic gateOn;
	logic byteDone;
	logic fluxLow;

	assign gateOn = floppyMode && floppy_ff[spfp_pkg::FL_GATE];
	// Data only moves once the gate has led by at least one cycle
	assign wrLoad = regWe && awAddr_ff == spfp_pkg::ADDR_WDATA && gateLead_ff
		&& wrState_ff == SPFP_WR_IDLE;
	assign byteStart = wrLoad;
	assign byteDone = wrState_ff == SPFP_WR_CELL && wrCnt_ff == 16'h0000
		&& wrBit_ff == 3'h0 && gateOn;
	assign fluxLow = wrState_ff == SPFP_WR_CELL && wrShift_ff[7]
		&& wrCnt_ff >= 16'(BIT_CELL - FLUX_LOW);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			gateLead_ff <= 1'b0;
			wrState_ff <= SPFP_WR_IDLE;
			wrShift_ff <= 8'h00;
			wrBit_ff <= 3'h0;
			wrCnt_ff <= 16'h0000;
		end else begin
			gateLead_ff <= gateOn;
			unique case (wrState_ff)
				SPFP_WR_IDLE: begin
					if (byteStart) begin
						wrState_ff <= SPFP_WR_CELL;
						wrShift_ff <= wData_ff;
						wrBit_ff <= 3'h7;
						wrCnt_ff <= 16'(BIT_CELL - 1);
					end
				end
				SPFP_WR_CELL: begin
					// Dropping the gate abandons the byte mid-way
					if (!gateOn) begin
						wrState_ff <= SPFP_WR_IDLE;
					end else if (wrCnt_ff != 16'h0000) begin
						wrCnt_ff <= wrCnt_ff - 16'h0001;
					end else if (wrBit_ff == 3'h0) begin
						wrState_ff <= SPFP_WR_IDLE;
					end else begin
						wrShift_ff <= {wrShift_ff[6:0], 1'b0};
						wrBit_ff <= wrBit_ff - 3'h1;
						wrCnt_ff <= 16'(BIT_CELL - 1);
					end
				end
			endcase
		end
	end

	assign fstatByte = {6'h00, wrState_ff == SPFP_WR_CELL, stepState_ff != SPFP_STEP_IDLE};

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic [7:0] irqEvents;
	logic irqRead;
	logic irq_ff;

	assign irqEvents = {5'h00,
		!floppyMode && busyPrev_ff && !padSync_ff.busyMotor,
		byteDone,
		stepDone};
	assign irqRead = doRead && s_axi_araddr == spfp_pkg::ADDR_IRQ_STAT;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irqStat_ff <= 8'h00;
			irq_ff <= 1'b0;
		end else begin
			// An event in the clearing cycle survives the read
			irqStat_ff <= (irqRead ? 8'h00 : irqStat_ff) | irqEvents;
			irq_ff <= |(irqStat_ff & irqMask_ff);
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	spfp_pkg::spfp_pad_t padOut_ff;
	spfp_pkg::spfp_pad_t padOe_ff;
	logic autoFeedMotorN_ff;
	logic initDir_ff;
	logic chooseStepN_ff;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			padOut_ff <= '1;
			padOe_ff <= '0;
			autoFeedMotorN_ff <= 1'b1;
			initDir_ff <= 1'b1;
			chooseStepN_ff <= 1'b1;
		end else if (floppyMode) begin
			padOe_ff <= '1;
			padOut_ff.busyMotor <= ~floppy_ff[spfp_pkg::FL_MOTOR];
			padOut_ff.mediaWdata <= ~fluxLow;
			padOut_ff.onlineGate <= ~gateOn;
			padOut_ff.faultSide <= ~floppy_ff[spfp_pkg::FL_SIDE1];
			autoFeedMotorN_ff <= ~floppy_ff[spfp_pkg::FL_MOTOR];
			initDir_ff <= ~floppy_ff[spfp_pkg::FL_INWARD];
			chooseStepN_ff <= stepState_ff != SPFP_STEP_LOW;
		end else begin
			// Printer side only listens on the two-way pads
			padOe_ff <= '0;
			padOut_ff <= '1;
			autoFeedMotorN_ff <= ~control_ff[spfp_pkg::CT_AUTOFEED];
			initDir_ff <= control_ff[spfp_pkg::CT_INIT];
			chooseStepN_ff <= ~control_ff[spfp_pkg::CT_CHOOSE];
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready = wready_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign padOut = padOut_ff;
	assign padOe = padOe_ff;
	assign autoFeedMotorN = autoFeedMotorN_ff;
	assign initDir = initDir_ff;
	assign chooseStepN = chooseStepN_ff;
	assign irq = irq_ff;

endmodule : spfp_port

// ---- src/spfp_pkg.sv ----
// Package: register map, timing figures and pad group for the shared printer/floppy port
package spfp_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_MODE = 8'h08;
	localparam logic [7:0] ADDR_FLOPPY = 8'h0C;
	localparam logic [7:0] ADDR_STEP = 8'h10;
	localparam logic [7:0] ADDR_WDATA = 8'h14;
	localparam logic [7:0] ADDR_FSTAT = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ST_NOT_BUSY = 7;
	localparam int ST_MEDIA = 5;
	localparam int ST_ONLINE = 4;
	localparam int ST_FAULT_N = 3;
	localparam int CT_AUTOFEED = 1;
	localparam int CT_INIT = 2;
	localparam int CT_CHOOSE = 3;
	localparam int MD_FLOPPY = 0;
	localparam int FL_SIDE1 = 0;
	localparam int FL_INWARD = 1;
	localparam int FL_MOTOR = 2;
	localparam int FL_GATE = 3;
	localparam int FS_STEPPING = 0;
	localparam int FS_WRITING = 1;
	localparam int IRQ_STEP_DONE = 0;
	localparam int IRQ_BYTE_DONE = 1;
	localparam int IRQ_READY = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CONTROL = 8'h04;
	localparam logic [7:0] RST_MODE = 8'h00;
	localparam logic [7:0] RST_FLOPPY = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int STEP_LOW_NS = 1000;
	localparam int STEP_GAP_NS = 3000;
	localparam int BIT_CELL_NS = 2000;
	localparam int FLUX_LOW_NS = 250;
	localparam int STEP_LOW_CYC = (STEP_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int STEP_GAP_CYC = (STEP_GAP_NS * CLK_MHZ + 999) / 1000;
	localparam int BIT_CELL_CYC = (BIT_CELL_NS * CLK_MHZ + 999) / 1000;
	localparam int FLUX_LOW_CYC = (FLUX_LOW_NS * CLK_MHZ + 999) / 1000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Four two-way pads, printer input vs floppy output
	typedef struct packed {
		logic faultSide;
		logic onlineGate;
		logic mediaWdata;
		logic busyMotor;
	} spfp_pad_t;

endpackage : spfp_pkg

// ---- tb/spfp_port_props.sv ----
// Checker: pad-level assertions for the shared printer/floppy port
`timescale 1ns/1ps
module spfp_port_props #(
	parameter int STEP_LOW = 2,
	parameter int STEP_GAP = 3,
	parameter int FLUX_LOW = 2
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire spfp_pkg::spfp_pad_t padOut,
	input wire spfp_pkg::spfp_pad_t padOe,
	input wire logic autoFeedMotorN,
	input wire logic initDir,
	input wire logic chooseStepN
);
	logic [15:0] lowCnt_ff;
	logic [15:0] highCnt_ff;
	logic [15:0] fluxCnt_ff;
	logic flop;
	assign flop = (padOe == 4'hF);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Gap count saturates, so a long idle gap never wraps into a false short one
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lowCnt_ff <= 16'h0000;
			highCnt_ff <= 16'h0000;
			fluxCnt_ff <= 16'h0000;
		end else begin
			lowCnt_ff <= chooseStepN ? 16'h0000 : lowCnt_ff + 16'h0001;
			highCnt_ff <= !chooseStepN ? 16'h0000 : highCnt_ff + {15'h0000, highCnt_ff != 16'hFFFF};
			fluxCnt_ff <= padOut.mediaWdata ? 16'h0000 : fluxCnt_ff + 16'h0001;
		end
	end
	oe_split_a: assert property (padOe == 4'h0 || padOe == 4'hF)
		else $error("pad enables split between functions");
	step_width_a: assert property (flop && $past(flop) && $rose(chooseStepN) |-> lowCnt_ff == STEP_LOW)
		else $error("step pulse width wrong");
	step_gap_a: assert property (flop && $past(flop) && $fell(chooseStepN) |-> highCnt_ff >= STEP_GAP)
		else $error("step pulses too close");
	flux_width_a: assert property (flop && $past(flop) && $rose(padOut.mediaWdata) |-> fluxCnt_ff == FLUX_LOW)
		else $error("flux pulse width wrong");
	gate_lead_a: assert property (flop && $fell(padOut.mediaWdata) |-> !padOut.onlineGate && !$past(padOut.onlineGate))
		else $error("write data without prior gate");
	flux_gated_a: assert property (flop && !padOut.mediaWdata |-> !padOut.onlineGate)
		else $error("write data low with gate off");
	motor_pin_a: assert property (flop |-> padOut.busyMotor == autoFeedMotorN)
		else $error("motor select pins disagree");
	dir_hold_a: assert property (flop && $past(flop) && !chooseStepN && !$past(chooseStepN) |-> $stable(initDir))
		else $error("direction moved during step");
endmodule : spfp_port_props

bind spfp_port spfp_port_props #(.STEP_LOW(STEP_LOW), .STEP_GAP(STEP_GAP), .FLUX_LOW(FLUX_LOW)) uProps (
	.clk_sys(clk_sys), .rstn(rstn), .padOut(padOut), .padOe(padOe),
	.autoFeedMotorN(autoFeedMotorN), .initDir(initDir), .chooseStepN(chooseStepN));

// ---- tb/spfp_far_model.sv ----
// Partner model: printer levels on the shared pads, or a floppy drive
`timescale 1ns/1ps
module spfp_far_model (
	input wire logic clk_sys,
	input wire spfp_pkg::spfp_pad_t padOut,
	input wire spfp_pkg::spfp_pad_t padOe,
	input wire logic initDir,
	input wire logic chooseStepN,
	input wire logic [3:0] prnLvl,
	output spfp_pkg::spfp_pad_t padIn,
	output int track,
	output int fluxFalls
);
	// Device drive wins where enabled; printer drives busy high when not ready
	assign padIn = spfp_pkg::spfp_pad_t'((padOe & padOut) | (~padOe & prnLvl));
	initial begin
		track = 0;
		fluxFalls = 0;
	end
	always @(negedge chooseStepN) begin
		if (padOe == 4'hF) track += initDir ? -1 : 1;
	end
	// Only transitions with write current on reach the medium
	always @(negedge padOut.mediaWdata) begin
		if (padOe == 4'hF && !padOut.onlineGate) fluxFalls++;
	end
endmodule : spfp_far_model

// ---- tb/shared_printer_floppy_port_tb_top.sv ----
// Testbench: shared printer/floppy port against a behavioural model
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module shared_printer_floppy_port_tb_top;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, autoFeedMotorN, initDir, chooseStepN;
	logic [31:0] wdata = 32'h00000000, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic [3:0] prnLvl = 4'hC;
	spfp_pkg::spfp_pad_t padIn, padOut, padOe;
	int miscompares = 0;
	int n_compared = 0;
	int track, fluxFalls, v, exp;
	always #5 clk_sys = ~clk_sys;
	spfp_port #(.STEP_LOW(2), .STEP_GAP(3), .BIT_CELL(8), .FLUX_LOW(2)) DUT (
		.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.padIn(padIn), .padOut(padOut), .padOe(padOe), .autoFeedMotorN(autoFeedMotorN),
		.initDir(initDir), .chooseStepN(chooseStepN), .irq(irq));
	spfp_far_model FAR (.clk_sys(clk_sys), .padOut(padOut), .padOe(padOe), .initDir(initDir),
		.chooseStepN(chooseStepN), .prnLvl(prnLvl), .padIn(padIn), .track(track),
		.fluxFalls(fluxFalls));
	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	// Waits on the slave with no cycle limit; only the watchdog ends a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end while (!(!aw && !w && bvalid === 1'b1));
		bready <= 1'b0;
		`CHK(bresp, er)
		// Idle edge, so a following call never re-raises bready in the same step
		@(posedge clk_sys);
	endtask : wr
	task automatic rd_reg(input logic [7:0] a);
		logic ar;
		ar = 1'b1;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (ar && arready === 1'b1) begin
				ar = 1'b0;
				arvalid <= 1'b0;
			end
		end while (!(!ar && rvalid === 1'b1));
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge clk_sys);
	endtask : rd_reg
	// Waits for a busy flag of the floppy status to drop
	task automatic poll(input int b);
		do begin
			rd_reg(spfp_pkg::ADDR_FSTAT);
		end while (rd[b] !== 1'b0);
	endtask : poll
	task automatic close_out();
		if (miscompares == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		v = $urandom(32'h0A9F23B0);
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		cyc(4);
		`CHK({autoFeedMotorN, initDir, chooseStepN}, 3'b111)
		`CHK(padOe, 4'h0)
		for (int i = 0; i < 8; i++) begin
			v = $urandom;
			prnLvl <= v[3:0];
			cyc(4);
			rd_reg(spfp_pkg::ADDR_STATUS);
			`CHK(rd[7], ~v[0])
			`CHK(rd[5], v[1])
			`CHK(rd[4], v[2])
			`CHK(rd[3], v[3])
		end
		for (int i = 0; i < 8; i++) begin
			v = $urandom & 32'h0000000E;
			wr(spfp_pkg::ADDR_CONTROL, v, spfp_pkg::RESP_OKAY);
			cyc(2);
			`CHK(autoFeedMotorN, ~v[1])
			`CHK(initDir, v[2])
			`CHK(chooseStepN, ~v[3])
			rd_reg(spfp_pkg::ADDR_CONTROL);
			`CHK(rd[3:0], v[3:0])
		end
		wr(8'h40, 32'h000000FF, spfp_pkg::RESP_SLVERR);
		rd_reg(8'h40);
		`CHK({rs, rd}, {spfp_pkg::RESP_SLVERR, 32'h00000000})
		for (int m = 0; m < 2; m++) begin
			wr(spfp_pkg::ADDR_IRQ_MASK, m * 4, spfp_pkg::RESP_OKAY);
			prnLvl <= 4'hD;
			cyc(4);
			rd_reg(spfp_pkg::ADDR_IRQ_STAT);
			prnLvl <= 4'hC;
			cyc(5);
			`CHK(irq, m[0])
			rd_reg(spfp_pkg::ADDR_IRQ_STAT);
			`CHK(rd[2], 1'b1)
			cyc(2);
			`CHK(irq, 1'b0)
		end
		wr(spfp_pkg::ADDR_MODE, 1, spfp_pkg::RESP_OKAY);
		cyc(2);
		`CHK(padOe, 4'hF)
		for (int i = 0; i < 8; i++) begin
			v = i;
			wr(spfp_pkg::ADDR_FLOPPY, v, spfp_pkg::RESP_OKAY);
			cyc(2);
			`CHK(padOut.faultSide, ~v[0])
			`CHK(initDir, ~v[1])
			`CHK({autoFeedMotorN, padOut.busyMotor}, {2{~v[2]}})
		end
		// Second count lands while stepping and must be dropped
		for (int d = 0; d < 2; d++) begin
			exp = track + (d == 1 ? 3 : -3);
			wr(spfp_pkg::ADDR_FLOPPY, d * 2, spfp_pkg::RESP_OKAY);
			wr(spfp_pkg::ADDR_STEP, 3, spfp_pkg::RESP_OKAY);
			wr(spfp_pkg::ADDR_STEP, 5, spfp_pkg::RESP_OKAY);
			poll(spfp_pkg::FS_STEPPING);
			`CHK(track, exp)
		end
		wr(spfp_pkg::ADDR_FLOPPY, 8, spfp_pkg::RESP_OKAY);
		cyc(2);
		`CHK(padOut.onlineGate, 1'b0)
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 32'h80 : ($urandom & 32'hFF);
			exp = fluxFalls + $countones(v[7:0]);
			wr(spfp_pkg::ADDR_WDATA, v, spfp_pkg::RESP_OKAY);
			poll(spfp_pkg::FS_WRITING);
			`CHK(fluxFalls, exp)
		end
		rd_reg(spfp_pkg::ADDR_IRQ_STAT);
		`CHK(rd[1:0], 2'b11)
		wr(spfp_pkg::ADDR_FLOPPY, 0, spfp_pkg::RESP_OKAY);
		exp = fluxFalls;
		wr(spfp_pkg::ADDR_WDATA, 32'hFF, spfp_pkg::RESP_OKAY);
		cyc(80);
		`CHK(fluxFalls, exp)
		wr(spfp_pkg::ADDR_MODE, 0, spfp_pkg::RESP_OKAY);
		cyc(2);
		`CHK(padOe, 4'h0)
		close_out();
	end
	initial begin
		#400000;
		miscompares++;
		close_out();
	end
endmodule : shared_printer_floppy_port_tb_top
